// >>> lsbf_sink9.sv
`timescale 1ns/100ps
module lsbf_sink9
	import lsbf_pkg::*;
#(
	parameter int unsigned OFF_STEP_CYC = LSBF_OFF_STEP_CYC,
	parameter int unsigned FADE_STEP_CYC = LSBF_FADE_STEP_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sink nine control
	input wire logic sink_enable,
	input wire logic on_expired,
	// Sink nine drive
	output logic [6:0] sink_level,
	output logic sink_on,
	output logic hold_off
);

	lsbf_ramp_if rif ();

	logic [6:0] off9_ff;
	logic [7:0] fade_ff;
	logic [7:0] rdata_ff;
	lsbf_state_e state_ff;
	lsbf_state_e nxt_state;
	logic start_ff;
	logic dir_up_ff;
	logic [5:0] units_ff;
	logic [31:0] pre_cnt_ff;
	logic [6:0] step_cnt_ff;
	logic sink_on_ff;
	logic hold_off_ff;
	logic ramp_done;
	logic [6:0] off_target;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------

	// Bit 7 of the off timer is reserved and not stored
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			off9_ff <= LSBF_OFF9_RST;
			fade_ff <= LSBF_FADE_RST;
		end else if (reg_wr) begin
			if (reg_addr == LSBF_ADDR_OFF9) begin
				off9_ff <= reg_wdata[6:0];
			end
			if (reg_addr == LSBF_ADDR_FADE) begin
				fade_ff <= reg_wdata;
			end
		end
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				LSBF_ADDR_OFF9: rdata_ff <= {1'b0, off9_ff};
				LSBF_ADDR_FADE: rdata_ff <= fade_ff;
				LSBF_ADDR_STAT: rdata_ff <= {2'b00, state_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Blink sequencer
	// ------------------------------------------------------------

	// A ramp just started has not raised busy yet, so wait a cycle
	assign ramp_done = !start_ff && !rif.busy;
	assign off_target = off9_ff - 7'd1;

	// Next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (sink_enable) nxt_state = ST_FADE_IN;
			end
			ST_FADE_IN: begin
				if (ramp_done) nxt_state = ST_ON;
			end
			ST_ON: begin
				if (on_expired && off9_ff != LSBF_OFF_CONT) nxt_state = ST_FADE_OUT;
			end
			ST_FADE_OUT: begin
				if (ramp_done) begin
					nxt_state = (off9_ff == LSBF_OFF_HOLD) ? ST_HOLD : ST_OFF_WAIT;
				end
			end
			ST_OFF_WAIT: begin
				if (off9_ff == LSBF_OFF_CONT || step_cnt_ff == off_target) nxt_state = ST_FADE_IN;
				else if (off9_ff == LSBF_OFF_HOLD) nxt_state = ST_HOLD;
			end
			ST_HOLD: begin
				if (off9_ff == LSBF_OFF_CONT) nxt_state = ST_FADE_IN;
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (!sink_enable) nxt_state = ST_IDLE;
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Ramp launch on entry to a fade state
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			start_ff <= 1'b0;
			dir_up_ff <= 1'b0;
			units_ff <= 6'd0;
		end else begin
			start_ff <= (nxt_state != state_ff) && (nxt_state == ST_FADE_IN || nxt_state == ST_FADE_OUT);
			dir_up_ff <= (nxt_state == ST_FADE_IN);
			units_ff <= (nxt_state == ST_FADE_IN)
				? lsbf_fade_units(fade_ff[LSBF_FI_HI:LSBF_FI_LO])
				: lsbf_fade_units(fade_ff[LSBF_FO_HI:LSBF_FO_LO]);
		end
	end

	// Off time in 100 ms steps; code one leaves no wait at all
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_cnt_ff <= 32'h0000_0000;
			step_cnt_ff <= 7'd0;
		end else if (state_ff != ST_OFF_WAIT) begin
			pre_cnt_ff <= 32'h0000_0000;
			step_cnt_ff <= 7'd0;
		end else if (pre_cnt_ff == OFF_STEP_CYC - 1) begin
			pre_cnt_ff <= 32'h0000_0000;
			step_cnt_ff <= step_cnt_ff + 7'd1;
		end else begin
			pre_cnt_ff <= pre_cnt_ff + 32'd1;
		end
	end

	// Drive flags
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sink_on_ff <= 1'b0;
			hold_off_ff <= 1'b0;
		end else begin
			sink_on_ff <= (nxt_state == ST_FADE_IN || nxt_state == ST_ON || nxt_state == ST_FADE_OUT);
			hold_off_ff <= (nxt_state == ST_HOLD);
		end
	end

	assign rif.start = start_ff;
	assign rif.dir_up = dir_up_ff;
	assign rif.units = units_ff;
	assign rif.clr = (state_ff == ST_IDLE);

	lsbf_ramp #(
		.UNIT_CYC(FADE_STEP_CYC)
	) u_ramp (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.rif(rif)
	);

	assign reg_rdata = rdata_ff;
	assign sink_level = rif.level;
	assign sink_on = sink_on_ff;
	assign hold_off = hold_off_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_cont_stays_on: assert property (
		(state_ff == ST_ON && off9_ff == LSBF_OFF_CONT && sink_enable) |=> state_ff == ST_ON)
		else $error("sink left on state with off code zero");
	a_expiry_turns_off: assert property (
		(state_ff == ST_ON && on_expired && off9_ff != LSBF_OFF_CONT && sink_enable)
		|=> (state_ff == ST_FADE_OUT && start_ff && !dir_up_ff))
		else $error("on expiry did not start fade-out");
	a_off_wait_holds: assert property (
		(state_ff == ST_OFF_WAIT && sink_enable && off9_ff != LSBF_OFF_CONT
			&& off9_ff != LSBF_OFF_HOLD && step_cnt_ff != off_target) |=> state_ff == ST_OFF_WAIT)
		else $error("off wait ended early");
	a_off_step_tick: assert property (
		(state_ff == ST_OFF_WAIT && pre_cnt_ff == OFF_STEP_CYC - 1 && nxt_state == ST_OFF_WAIT)
		|=> step_cnt_ff == $past(step_cnt_ff) + 7'd1)
		else $error("off step not counted");
	a_off_wait_ends: assert property (
		(state_ff == ST_OFF_WAIT && sink_enable && step_cnt_ff == off_target)
		|=> (state_ff == ST_FADE_IN && start_ff && dir_up_ff))
		else $error("off wait did not end at its count");
	a_hold_stays_dark: assert property (
		(state_ff == ST_HOLD && sink_enable && off9_ff == LSBF_OFF_HOLD)
		|=> (state_ff == ST_HOLD && hold_off_ff && !sink_on_ff))
		else $error("held sink left dark state");
	a_fade_out_long: assert property (
		(start_ff && !dir_up_ff && fade_ff[LSBF_FO_HI:LSBF_FO_LO] == 4'hB) |-> units_ff == 6'd15)
		else $error("fade-out code eleven not 750 ms");
	a_fade_out_lin: assert property (
		(start_ff && !dir_up_ff && fade_ff[LSBF_FO_HI:LSBF_FO_LO] <= 4'hA)
		|-> units_ff == {2'b00, fade_ff[7:4]})
		else $error("fade-out linear code mismatch");
	a_fade_in_max: assert property (
		(start_ff && dir_up_ff && fade_ff[LSBF_FI_HI:LSBF_FI_LO] == 4'hF) |-> units_ff == 6'd35)
		else $error("fade-in code fifteen not 1.75 s");
	a_enable_fades_in: assert property (
		(state_ff == ST_IDLE && sink_enable) |=> (state_ff == ST_FADE_IN && start_ff && dir_up_ff))
		else $error("enable did not start fade-in");
	a_disable_idles: assert property (
		!sink_enable |=> (state_ff == ST_IDLE ##1 sink_level == 7'h00))
		else $error("disable did not clear sink");

	c_blink_cycle: cover property (state_ff == ST_FADE_OUT ##[1:1000] state_ff == ST_OFF_WAIT);
	c_run_once: cover property (state_ff == ST_FADE_OUT ##[1:1000] state_ff == ST_HOLD);
	c_relight: cover property (state_ff == ST_OFF_WAIT ##1 state_ff == ST_FADE_IN);
	c_full_on: cover property (state_ff == ST_ON && sink_level == LSBF_LEVEL_FULL);

endmodule // lsbf_sink9

// >>> lsbf_pkg.sv
// How it works
// - Off code zero keeps sink on
// - Codes 1 to 126: off for duration, then on
// - Off time is (code minus one) tenths
// - Code all ones holds sink dark
// - Fade-out field bits 7:4, full to zero
// - Fade-out: linear 50 ms, then 250 ms steps
// - Fade-in field bits 3:0, zero to full
// - Fade-in encoding matches fade-out encoding
package lsbf_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] LSBF_ADDR_OFF9 = 8'h21;
	localparam logic [7:0] LSBF_ADDR_FADE = 8'h22;
	localparam logic [7:0] LSBF_ADDR_STAT = 8'h30;
	localparam logic [6:0] LSBF_OFF9_RST = 7'h00;
	localparam logic [7:0] LSBF_FADE_RST = 8'h00;
	localparam int LSBF_FO_HI = 7;
	localparam int LSBF_FO_LO = 4;
	localparam int LSBF_FI_HI = 3;
	localparam int LSBF_FI_LO = 0;

	// ------------------------------------------------------------
	// Code points
	// ------------------------------------------------------------
	localparam logic [6:0] LSBF_OFF_CONT = 7'h00;
	localparam logic [6:0] LSBF_OFF_HOLD = 7'h7F;
	localparam logic [3:0] LSBF_FADE_LIN_MAX = 4'hA;
	localparam logic [5:0] LSBF_FADE_LONG_BASE = 6'h0F;
	localparam logic [5:0] LSBF_FADE_LONG_STEP = 6'h05;
	localparam logic [6:0] LSBF_LEVEL_FULL = 7'h7F;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned LSBF_CLK_KHZ = 100000;
	localparam int unsigned LSBF_OFF_STEP_MS = 100;
	localparam int unsigned LSBF_FADE_STEP_MS = 50;
	localparam int unsigned LSBF_OFF_STEP_CYC = LSBF_OFF_STEP_MS * LSBF_CLK_KHZ;
	localparam int unsigned LSBF_FADE_STEP_CYC = LSBF_FADE_STEP_MS * LSBF_CLK_KHZ;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE     = 6'b00_0001,
		ST_FADE_IN  = 6'b00_0010,
		ST_ON       = 6'b00_0100,
		ST_FADE_OUT = 6'b00_1000,
		ST_OFF_WAIT = 6'b01_0000,
		ST_HOLD     = 6'b10_0000
	} lsbf_state_e;

	// Fade code to 50 ms units; same table both directions
	function automatic logic [5:0] lsbf_fade_units(input logic [3:0] code);
		logic [5:0] units;
		units = {2'b00, code};
		if (code > LSBF_FADE_LIN_MAX) begin
			units = LSBF_FADE_LONG_BASE + LSBF_FADE_LONG_STEP * {2'b00, code - 4'hB};
		end
		return units;
	endfunction

endpackage

// >>> lsbf_ramp_if.sv
`timescale 1ns/100ps
// Sequencer to ramp generator
interface lsbf_ramp_if;
	logic start;
	logic dir_up;
	logic clr;
	logic [5:0] units;
	logic [6:0] level;
	logic busy;
	modport ctrl (output start, output dir_up, output clr, output units, input level, input busy);
	modport ramp (input start, input dir_up, input clr, input units, output level, output busy);
endinterface

// >>> lsbf_ramp.sv
`timescale 1ns/100ps
module lsbf_ramp
	import lsbf_pkg::*;
#(
	parameter int unsigned UNIT_CYC = LSBF_FADE_STEP_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Sequencer side
	lsbf_ramp_if.ramp rif
);

	logic [31:0] acc_ff;
	logic [31:0] total_ff;
	logic [6:0] level_ff;
	logic busy_ff;
	logic up_ff;
	logic [31:0] nxt_acc;
	logic [6:0] target;

	assign nxt_acc = acc_ff + {25'd0, LSBF_LEVEL_FULL};
	assign target = rif.dir_up ? LSBF_LEVEL_FULL : 7'h00;
	assign rif.level = level_ff;
	assign rif.busy = busy_ff;

	// Bresenham stepping: exactly 127 steps over the full-scale time,
	// so a partial ramp keeps the full-scale rate; at most one step a
	// clock, so a full-scale time under 127 clocks is stretched to 127
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acc_ff <= 32'h0000_0000;
			total_ff <= 32'h0000_0000;
			level_ff <= 7'h00;
			busy_ff <= 1'b0;
			up_ff <= 1'b0;
		end else if (rif.clr) begin
			level_ff <= 7'h00;
			busy_ff <= 1'b0;
		end else if (rif.start) begin
			up_ff <= rif.dir_up;
			acc_ff <= 32'h0000_0000;
			total_ff <= 32'(rif.units) * 32'(UNIT_CYC);
			if (rif.units == 6'd0) begin
				level_ff <= target;
				busy_ff <= 1'b0;
			end else begin
				busy_ff <= (level_ff != target);
			end
		end else if (busy_ff) begin
			if (nxt_acc >= total_ff) begin
				acc_ff <= nxt_acc - total_ff;
				level_ff <= up_ff ? level_ff + 7'd1 : level_ff - 7'd1;
				if ((up_ff && level_ff == LSBF_LEVEL_FULL - 7'd1) || (!up_ff && level_ff == 7'd1)) begin
					busy_ff <= 1'b0;
				end
			end else begin
				acc_ff <= nxt_acc;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ramp_jump: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(rif.start && !rif.clr && rif.units == 6'd0) |=> (!busy_ff && level_ff == $past(target)))
		else $error("zero fade code did not jump");
	a_ramp_rises: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(busy_ff && up_ff && !rif.start && !rif.clr) |=> (level_ff >= $past(level_ff)))
		else $error("fade-in ramp went down");
	a_ramp_falls: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(busy_ff && !up_ff && !rif.start && !rif.clr) |=> (level_ff <= $past(level_ff)))
		else $error("fade-out ramp went up");

endmodule // lsbf_ramp

// >>> tb.sv
`timescale 1ns/100ps
module tb;
	import lsbf_pkg::*;

	// ----------------------------------------------------------------
	// Signals, shortened counts and model state
	// ----------------------------------------------------------------
	// Short counts keep every blink cycle within a few thousand clocks;
	// the ramp steps once a clock at most, so a fade unit must be 127 or more
	localparam int unsigned OFF_CYC = 20;
	localparam int unsigned FADE_CYC = 127;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sink_enable = 1'b0;
	logic on_expired = 1'b0;
	logic [7:0] reg_rdata;
	logic [6:0] sink_level;
	logic sink_on;
	logic hold_off;
	int n_mismatch = 0;
	int check_count = 0;
	logic [7:0] mdl_off = 8'h00;
	logic [7:0] mdl_fade = 8'h00;
	logic [7:0] rv;
	int n;
	int codes[6];

	lsbf_sink9 #(.OFF_STEP_CYC(OFF_CYC), .FADE_STEP_CYC(FADE_CYC)) lsbf_sink9_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sink_enable(sink_enable),
		.on_expired(on_expired), .sink_level(sink_level), .sink_on(sink_on),
		.hold_off(hold_off));

	// Free-running 100 MHz clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Tolerance covers the one or two cycles of sequencer overhead
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input int tol);
		check_count++;
		if (seen === exp || (seen + tol >= exp && seen <= exp + tol)) begin
		end else begin
			n_mismatch++;
			$display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		if (a == LSBF_ADDR_OFF9) mdl_off = {1'b0, d[6:0]};
		if (a == LSBF_ADDR_FADE) mdl_fade = d;
	endtask

	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Full-scale fade time in clocks: linear to 10, then long steps
	function automatic int fade_cyc(input logic [3:0] c);
		int u;
		u = (c <= 10) ? int'(c) : 15 + 5 * (int'(c) - 11);
		return u * FADE_CYC;
	endfunction

	task automatic wait_lvl(input logic [6:0] v, output int cyc);
		cyc = 0;
		while (sink_level !== v && cyc < 6000) begin
			@(posedge sys_clk);
			#1 cyc++;
		end
	endtask

	task automatic wait_on(input logic v, output int cyc);
		cyc = 0;
		while (sink_on !== v && cyc < 6000) begin
			@(posedge sys_clk);
			#1 cyc++;
		end
	endtask

	// Settle into the on state first; a pulse in fade-in is ignored
	task automatic pulse_exp;
		repeat (3) @(posedge sys_clk);
		on_expired <= 1'b1;
		@(posedge sys_clk);
		on_expired <= 1'b0;
		#1;
	endtask

	// Disable clears the level two clocks later, before enable returns, so each run starts from zero
	task automatic restart(input logic [7:0] fade);
		@(posedge sys_clk);
		sink_enable <= 1'b0;
		wr(LSBF_ADDR_FADE, fade);
		@(posedge sys_clk);
		sink_enable <= 1'b1;
		#1;
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(79854));
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// Reset values, idle status, unmapped read, read data one cycle only
		rd(LSBF_ADDR_OFF9, rv);
		chk(rv, 8'h00, 0);
		rd(LSBF_ADDR_FADE, rv);
		chk(rv, 8'h00, 0);
		rd(LSBF_ADDR_STAT, rv);
		chk(rv, 8'h01, 0);
		rd(8'h40, rv);
		chk(rv, 8'h00, 0);
		@(posedge sys_clk);
		#1 chk(reg_rdata, 8'h00, 0);
		// Random writes; bit 7 of the off timer is reserved and reads zero
		for (int i = 0; i < 6; i++) begin
			wr(LSBF_ADDR_OFF9, 8'($urandom));
			wr(LSBF_ADDR_FADE, 8'($urandom));
			wr(8'h40, 8'($urandom));
			rd(LSBF_ADDR_OFF9, rv);
			chk(rv, mdl_off, 0);
			rd(LSBF_ADDR_FADE, rv);
			chk(rv, mdl_fade, 0);
		end
		$display("test registers done");
		// Off code zero: stays lit, timer expiry ignored
		wr(LSBF_ADDR_OFF9, 8'h00);
		restart(8'h00);
		wait_lvl(7'h7F, n);
		chk(n, 0, 3);
		pulse_exp;
		repeat (40) @(posedge sys_clk);
		#1 chk(sink_level, 7'h7F, 0);
		chk(sink_on, 1'b1, 0);
		rd(LSBF_ADDR_STAT, rv);
		chk(rv, 8'h04, 0);
		$display("test continuous on done");
		// Every fade-in code, fade-out nibble random to prove field split
		for (int c = 0; c < 16; c++) begin
			restart({4'($urandom), 4'(c)});
			wait_lvl(7'h7F, n);
			chk(n, fade_cyc(4'(c)), 3);
		end
		$display("test fade-in done");
		// Every fade-out code with the hold code: one blink, then dark
		wr(LSBF_ADDR_OFF9, 8'h7F);
		for (int c = 0; c < 16; c++) begin
			restart({4'(c), 4'h0});
			wait_lvl(7'h7F, n);
			pulse_exp;
			wait_lvl(7'h00, n);
			chk(n, fade_cyc(4'(c)), 3);
			repeat (100) @(posedge sys_clk);
			#1 chk(hold_off, 1'b1, 0);
			chk(sink_level, 7'h00, 0);
			chk(sink_on, 1'b0, 0);
			rd(LSBF_ADDR_STAT, rv);
			chk(rv, 8'h20, 0);
		end
		// Off code zero written while held dark relights the sink
		wr(LSBF_ADDR_OFF9, 8'h00);
		wait_on(1'b1, n);
		chk(n, 0, 3);
		chk(hold_off, 1'b0, 0);
		$display("test fade-out and hold done");
		// Off wait per code, boundaries and one random; relight fades in
		codes = '{1, 2, 3, 5, 126, 0};
		codes[5] = 2 + int'($urandom % 124);
		for (int k = 0; k < 6; k++) begin
			// Fade-out kept nonzero beside the zero-second code
			wr(LSBF_ADDR_OFF9, 8'(codes[k]));
			restart(8'h11);
			wait_lvl(7'h7F, n);
			pulse_exp;
			wait_on(1'b0, n);
			chk(hold_off, 1'b0, 0);
			wait_on(1'b1, n);
			chk(n, (codes[k] - 1) * OFF_CYC, 3);
			wait_lvl(7'h7F, n);
			chk(n, fade_cyc(4'h1), 3);
		end
		$display("test off timer done");
		wrap_up;
	end

	// Whole run needs about 56,000 clocks; cut a hang well beyond that
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up;
	end

endmodule // tb
